// ===== pkg/rmcs_if.sv
// Command and event link between controller and device
`timescale 1ns/1ps
`default_nettype none
interface rmcs_if;
   logic                             cmd_valid;
   rmcs_pkg::rmcs_cmd_t              cmd_code;
   logic [rmcs_pkg::UUID_W-1:0]      cmd_arg;
   logic [rmcs_pkg::BASE_IDX_W-1:0]  cmd_idx;
   logic                             evt_valid;
   rmcs_pkg::rmcs_evt_t              evt_code;
   logic [rmcs_pkg::DATA_W-1:0]      evt_arg;

   modport device (
      input  cmd_valid, cmd_code, cmd_arg, cmd_idx,
      output evt_valid, evt_code, evt_arg
   );
   modport ctrl (
      output cmd_valid, cmd_code, cmd_arg, cmd_idx,
      input  evt_valid, evt_code, evt_arg
   );
endinterface : rmcs_if
`default_nettype wire

// ===== pkg/rmcs_pkg.sv
// Package for the radio mode command sequencer
package rmcs_pkg;
   localparam int CMD_W        = 4;
   localparam int EVT_W        = 4;
   localparam int DATA_W       = 8;
   localparam int UUID_W       = 128;
   localparam int SHORT_W      = 16;
   localparam int SHORT_LSB    = 96;
   localparam int NUM_BASES    = 5;
   localparam int BASE_IDX_W   = 3;
   localparam int CLK_HZ       = 40_000_000;
   localparam int CFG_BYTES    = 1616;
   localparam int VOL_WR_MS    = 50;
   localparam int NVM_WR_MS    = 1600;
   localparam int ANSWER_MS    = 2000;
   localparam int VOL_WR_CYC   = VOL_WR_MS * (CLK_HZ / 1000);
   localparam int NVM_WR_CYC   = NVM_WR_MS * (CLK_HZ / 1000);
   localparam int ANSWER_CYC   = ANSWER_MS * (CLK_HZ / 1000);
   localparam int ADV_TO_CYC   = 4_000_000;
   localparam int CNT_W        = 32;

   typedef enum logic [3:0] {
      RMCS_CMD_NONE    = 4'h0,
      RMCS_CMD_SLEEP   = 4'h1,
      RMCS_CMD_WAKEUP  = 4'h2,
      RMCS_CMD_SETUP   = 4'h3,
      RMCS_CMD_TEST    = 4'h4,
      RMCS_CMD_CFG_VOL = 4'h5,
      RMCS_CMD_CFG_NVM = 4'h6,
      RMCS_CMD_CONNECT = 4'h7,
      RMCS_CMD_BOND    = 4'h8,
      RMCS_CMD_DATA    = 4'h9,
      RMCS_CMD_BASE    = 4'hA
   } rmcs_cmd_t;

   typedef enum logic [3:0] {
      RMCS_EVT_NONE    = 4'h0,
      RMCS_EVT_READY   = 4'h1,
      RMCS_EVT_DONE    = 4'h2,
      RMCS_EVT_ERROR   = 4'h3,
      RMCS_EVT_LINK_UP = 4'h4,
      RMCS_EVT_CHANNEL = 4'h5,
      RMCS_EVT_ADV_TO  = 4'h6,
      RMCS_EVT_LINK_DN = 4'h7,
      RMCS_EVT_DATA_RX = 4'h8
   } rmcs_evt_t;

   typedef enum logic [2:0] {
      RMCS_M_SLEEP   = 3'h0,
      RMCS_M_SETUP   = 3'h1,
      RMCS_M_STANDBY = 3'h2,
      RMCS_M_ADV     = 3'h3,
      RMCS_M_CONN    = 3'h4,
      RMCS_M_TEST    = 3'h5,
      RMCS_M_BUSY    = 3'h6
   } rmcs_mode_t;

   typedef enum logic [1:0] {
      RMCS_ADV_NONE    = 2'h0,
      RMCS_ADV_GENERAL = 2'h1,
      RMCS_ADV_LIMITED = 2'h2,
      RMCS_ADV_NONDISC = 2'h3
   } rmcs_adv_t;
endpackage : rmcs_pkg

// ===== rtl/rmcs_base_store.sv
// Storage of base identifiers with short-form substitution
`timescale 1ns/1ps
`default_nettype none
module rmcs_base_store #(
   parameter int NUM = rmcs_pkg::NUM_BASES
) (
   input  wire logic                             clk,
   input  wire logic                             sys_rst,
   input  wire logic                             wr_en,
   input  wire logic [rmcs_pkg::BASE_IDX_W-1:0]  wr_idx,
   input  wire logic [rmcs_pkg::UUID_W-1:0]      wr_base,
   input  wire logic [rmcs_pkg::BASE_IDX_W-1:0]  rd_idx,
   input  wire logic [rmcs_pkg::SHORT_W-1:0]     rd_short,
   output logic      [rmcs_pkg::UUID_W-1:0]      rd_uuid
);
   logic [rmcs_pkg::UUID_W-1:0] base_q [NUM];
   logic [rmcs_pkg::UUID_W-1:0] sel_base;

   genvar g;
   generate
      for (g = 0; g < NUM; g++) begin : g_base
         always_ff @(posedge clk) begin
            if (sys_rst)
               base_q[g] <= '0;
            else if (wr_en && 32'(wr_idx) == g)
               base_q[g] <= wr_base;
         end
      end
   endgenerate

   assign sel_base = (32'(rd_idx) < NUM) ? base_q[rd_idx] : '0;
   // Short form sits in bytes 13 and 14
   always_comb begin
      rd_uuid = sel_base;
      rd_uuid[rmcs_pkg::SHORT_LSB +: rmcs_pkg::SHORT_W] = rd_short;
   end
endmodule : rmcs_base_store
`default_nettype wire

// ===== rtl/rmcs_ctrl.sv
// Controller end: issues one command at a time after readiness
`timescale 1ns/1ps
`default_nettype none
module rmcs_ctrl #(
   parameter int ANS_CYC = rmcs_pkg::ANSWER_CYC
) (
   input  wire logic                              clk,
   input  wire logic                              sys_rst,
   rmcs_if.ctrl                                   link,
   input  wire logic                              req_valid,
   input  wire logic [rmcs_pkg::CMD_W-1:0]        req_code,
   input  wire logic [rmcs_pkg::UUID_W-1:0]       req_arg,
   input  wire logic [rmcs_pkg::BASE_IDX_W-1:0]   req_idx,
   output logic                                   req_ready,
   output logic                                   done,
   output logic      [rmcs_pkg::EVT_W-1:0]        done_code,
   output logic                                   timeout,
   output logic                                   connected
);
   logic ready_q, open_q, busy_q, conn_q, cv_q, done_q, to_q;
   logic [rmcs_pkg::EVT_W-1:0] dc_q;
   rmcs_pkg::rmcs_cmd_t cc_q;
   logic [rmcs_pkg::UUID_W-1:0] arg_q;
   logic [rmcs_pkg::BASE_IDX_W-1:0] idx_q;
   logic [rmcs_pkg::CNT_W-1:0] wait_q;

   wire ev = link.evt_valid;
   wire ans = ev && (link.evt_code == rmcs_pkg::RMCS_EVT_DONE ||
                     link.evt_code == rmcs_pkg::RMCS_EVT_ERROR);
   wire is_data = req_code == rmcs_pkg::RMCS_CMD_DATA;
   // Data waits for an open channel; blocked requests are simply held off
   wire may = ready_q && !busy_q && !cv_q && (!is_data || open_q);
   wire take = req_valid && may;
   wire drop = ev && (link.evt_code == rmcs_pkg::RMCS_EVT_LINK_DN ||
                      link.evt_code == rmcs_pkg::RMCS_EVT_ADV_TO);
   wire sleep_req = req_code == rmcs_pkg::RMCS_CMD_SLEEP;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ready_q <= 1'b0;
         open_q  <= 1'b0;
         busy_q  <= 1'b0;
         conn_q  <= 1'b0;
         cv_q    <= 1'b0;
         cc_q    <= rmcs_pkg::RMCS_CMD_NONE;
         arg_q   <= '0;
         idx_q   <= '0;
         wait_q  <= '0;
         done_q  <= 1'b0;
         dc_q    <= '0;
         to_q    <= 1'b0;
      end else begin
         if (ev && link.evt_code == rmcs_pkg::RMCS_EVT_READY)
            ready_q <= 1'b1;
         if (ev && link.evt_code == rmcs_pkg::RMCS_EVT_CHANNEL &&
             link.evt_arg != '0)
            open_q <= 1'b1;
         else if (drop)
            open_q <= 1'b0;
         if (ev && link.evt_code == rmcs_pkg::RMCS_EVT_LINK_UP)
            conn_q <= 1'b1;
         else if (drop)
            conn_q <= 1'b0;
         cv_q <= take;
         if (take) begin
            // A sleep while linked goes out as RMCS_CMD_NONE, which the device answers with an error
            cc_q  <= (sleep_req && conn_q) ? rmcs_pkg::RMCS_CMD_NONE
                     : rmcs_pkg::rmcs_cmd_t'(req_code);
            arg_q <= req_arg;
            idx_q <= req_idx;
         end
         done_q <= ans && busy_q;
         dc_q   <= link.evt_code;
         to_q   <= busy_q && wait_q == 32'd1;
         if (cv_q) begin
            busy_q <= 1'b1;
            wait_q <= rmcs_pkg::CNT_W'(ANS_CYC);
         end else if (ans || wait_q == 32'd1) begin
            busy_q <= 1'b0;
            wait_q <= '0;
         end else if (wait_q != '0)
            wait_q <= wait_q - 32'd1;
      end
   end

   assign link.cmd_valid = cv_q;
   assign link.cmd_code  = cc_q;
   assign link.cmd_arg   = arg_q;
   assign link.cmd_idx   = idx_q;
   assign req_ready      = ready_q && !busy_q && !cv_q;
   assign done           = done_q;
   assign done_code      = dc_q;
   assign timeout        = to_q;
   assign connected      = conn_q;
endmodule : rmcs_ctrl
`default_nettype wire

// ===== rtl/rmcs_device.sv
// Device end: operating mode sequencer
// Notes on behaviour
// - Controller waits for device ready notice
// - Data waits for first open channel
// - Four modes, chosen by four commands
// - Setup or Test clears dynamic data
// - Reset enters Setup, Active if stored
// - Active has connected, advertising, standby
// - Setup completion enters Active
// - Controller disconnects before Sleep; controller instead sends a no-op code while linked, answered with error
// - Sleep drops link, keeps configuration
// - Sleep then Wakeup returns to standby
// - Stored configuration locked against rewrite
// - Volatile configuration lost on reset
// - No data before setup completes
// - Stored write much slower than volatile
// - Short form in bytes 13, 14
// - Five bases, short field substituted
// - Test, Setup, Sleep leave Active
// - Connect or Bond starts advertising
// - Advertise until link or timeout
// - Advertising flavour from command and bond
// - Link up then channel notice
// - Timeout or loss returns to standby
// - One command outstanding, answer within 2s
`timescale 1ns/1ps
`default_nettype none
module rmcs_device #(
   parameter int VOL_CYC = rmcs_pkg::VOL_WR_CYC,
   parameter int NVM_CYC = rmcs_pkg::NVM_WR_CYC,
   parameter int ADV_CYC = rmcs_pkg::ADV_TO_CYC
) (
   input  wire logic                          clk,
   input  wire logic                          sys_rst,
   rmcs_if.device                             link,
   input  wire logic                          nvm_cfg_present,
   input  wire logic                          peer_connect,
   input  wire logic                          peer_loss,
   input  wire logic                          peer_rx,
   input  wire logic [rmcs_pkg::DATA_W-1:0]   peer_rx_data,
   output logic                               radio_tx,
   output logic      [rmcs_pkg::DATA_W-1:0]   radio_tx_data,
   output rmcs_pkg::rmcs_mode_t               mode,
   output rmcs_pkg::rmcs_adv_t                adv_kind,
   output logic                               cfg_locked,
   output logic                               bonded,
   output logic      [rmcs_pkg::UUID_W-1:0]   uuid_out
);
   localparam int CNT_W = rmcs_pkg::CNT_W;
   rmcs_pkg::rmcs_mode_t mode_q, mode_d;
   logic                 started_q;
   logic [rmcs_pkg::CNT_W-1:0] cnt_q;
   logic                 nvm_s1_q, nvm_s2_q, conn_s1_q, conn_s2_q;
   logic                 loss_s1_q, loss_s2_q, rx_s1_q, rx_s2_q;
   logic [rmcs_pkg::DATA_W-1:0] rxd_s1_q, rxd_s2_q;
   logic                 cfg_q, lock_q, bond_q, bonding_q;
   rmcs_pkg::rmcs_adv_t  adv_q;
   logic                 evt_v_q, chan_pend_q, tx_q;
   rmcs_pkg::rmcs_evt_t  evt_c_q;
   logic [rmcs_pkg::DATA_W-1:0] evt_a_q, tx_data_q;

   wire cmd = link.cmd_valid && started_q;
   wire rmcs_pkg::rmcs_cmd_t cc = link.cmd_code;
   wire in_active = mode_q == rmcs_pkg::RMCS_M_STANDBY ||
                    mode_q == rmcs_pkg::RMCS_M_ADV ||
                    mode_q == rmcs_pkg::RMCS_M_CONN;
   wire is_busy = mode_q == rmcs_pkg::RMCS_M_BUSY;
   wire cnt_done = is_busy && cnt_q == '0;
   wire adv_to = mode_q == rmcs_pkg::RMCS_M_ADV && cnt_q == '0;
   wire c_sleep = cmd && cc == rmcs_pkg::RMCS_CMD_SLEEP && in_active;
   wire c_wake  = cmd && cc == rmcs_pkg::RMCS_CMD_WAKEUP &&
                  mode_q == rmcs_pkg::RMCS_M_SLEEP;
   wire c_setup = cmd && cc == rmcs_pkg::RMCS_CMD_SETUP && !is_busy &&
                  mode_q != rmcs_pkg::RMCS_M_SLEEP;
   wire c_test  = cmd && cc == rmcs_pkg::RMCS_CMD_TEST && !is_busy &&
                  mode_q != rmcs_pkg::RMCS_M_SLEEP;
   wire c_cfg   = cmd && mode_q == rmcs_pkg::RMCS_M_SETUP && !lock_q &&
                  (cc == rmcs_pkg::RMCS_CMD_CFG_VOL ||
                   cc == rmcs_pkg::RMCS_CMD_CFG_NVM);
   wire c_base  = cmd && cc == rmcs_pkg::RMCS_CMD_BASE &&
                  mode_q == rmcs_pkg::RMCS_M_SETUP && !lock_q;
   wire c_adv   = cmd && mode_q == rmcs_pkg::RMCS_M_STANDBY && cfg_q &&
                  (cc == rmcs_pkg::RMCS_CMD_CONNECT ||
                   cc == rmcs_pkg::RMCS_CMD_BOND);
   wire c_data  = cmd && cc == rmcs_pkg::RMCS_CMD_DATA &&
                  mode_q == rmcs_pkg::RMCS_M_CONN && cfg_q;
   wire ok = c_sleep | c_wake | c_setup | c_test | c_cfg | c_base |
             c_adv | c_data;
   wire bad = cmd && !ok;
   wire linked = mode_q == rmcs_pkg::RMCS_M_ADV && conn_s2_q;
   wire lost = mode_q == rmcs_pkg::RMCS_M_CONN && loss_s2_q;

   // Next mode
   always_comb begin
      mode_d = mode_q;
      if (c_sleep)
         mode_d = rmcs_pkg::RMCS_M_SLEEP;
      else if (c_wake)
         mode_d = rmcs_pkg::RMCS_M_STANDBY;
      else if (c_setup)
         mode_d = rmcs_pkg::RMCS_M_SETUP;
      else if (c_test)
         mode_d = rmcs_pkg::RMCS_M_TEST;
      else if (c_cfg)
         mode_d = rmcs_pkg::RMCS_M_BUSY;
      else if (c_adv)
         mode_d = rmcs_pkg::RMCS_M_ADV;
      else if (cnt_done)
         mode_d = rmcs_pkg::RMCS_M_STANDBY;
      else if (linked)
         mode_d = rmcs_pkg::RMCS_M_CONN;
      else if (adv_to || lost)
         mode_d = rmcs_pkg::RMCS_M_STANDBY;
   end

   always_ff @(posedge clk) begin
      nvm_s1_q  <= nvm_cfg_present;
      nvm_s2_q  <= nvm_s1_q;
      conn_s1_q <= peer_connect;
      conn_s2_q <= conn_s1_q;
      loss_s1_q <= peer_loss;
      loss_s2_q <= loss_s1_q;
      rx_s1_q   <= peer_rx;
      rx_s2_q   <= rx_s1_q;
      rxd_s1_q  <= peer_rx_data;
      rxd_s2_q  <= rxd_s1_q;
   end

   // Strap is caught after release, once the synchroniser has settled
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mode_q    <= rmcs_pkg::RMCS_M_SETUP;
         started_q <= 1'b0;
         cnt_q     <= '0;
      end else if (!started_q) begin
         started_q <= cnt_q == 32'd2;
         cnt_q     <= cnt_q + 32'd1;
         if (cnt_q == 32'd2) begin
            mode_q <= nvm_s2_q ? rmcs_pkg::RMCS_M_STANDBY
                               : rmcs_pkg::RMCS_M_SETUP;
            cnt_q  <= '0;
         end
      end else begin
         mode_q <= mode_d;
         if (c_cfg)
            cnt_q <= (cc == rmcs_pkg::RMCS_CMD_CFG_NVM) ?
                     CNT_W'(NVM_CYC - 1) : CNT_W'(VOL_CYC - 1);
         else if (c_adv)
            cnt_q <= CNT_W'(ADV_CYC - 1);
         else if (cnt_q != '0)
            cnt_q <= cnt_q - 32'd1;
      end
   end

   // Configuration, lock, bonding and dynamic data
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cfg_q     <= 1'b0;
         lock_q    <= 1'b0;
         bond_q    <= 1'b0;
         bonding_q <= 1'b0;
         adv_q     <= rmcs_pkg::RMCS_ADV_NONE;
      end else begin
         if (!started_q && cnt_q == 32'd2 && nvm_s2_q) begin
            cfg_q  <= 1'b1;
            lock_q <= 1'b1;
         end
         if (c_cfg && cc == rmcs_pkg::RMCS_CMD_CFG_NVM)
            lock_q <= 1'b1;
         if (cnt_done)
            cfg_q <= 1'b1;
         if (c_setup || c_test) begin
            bond_q <= 1'b0;
            if (!lock_q)
               cfg_q <= 1'b0;
         end
         if (c_adv) begin
            bonding_q <= cc == rmcs_pkg::RMCS_CMD_BOND;
            if (cc == rmcs_pkg::RMCS_CMD_BOND) begin
               adv_q  <= rmcs_pkg::RMCS_ADV_LIMITED;
               bond_q <= 1'b0;
            end else
               adv_q <= bond_q ? rmcs_pkg::RMCS_ADV_NONDISC
                               : rmcs_pkg::RMCS_ADV_GENERAL;
         end else if (mode_q != rmcs_pkg::RMCS_M_ADV)
            adv_q <= rmcs_pkg::RMCS_ADV_NONE;
         if (linked && bonding_q)
            bond_q <= 1'b1;
      end
   end

   // Events; channel notice trails link up by one cycle
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         evt_v_q     <= 1'b0;
         evt_c_q     <= rmcs_pkg::RMCS_EVT_NONE;
         evt_a_q     <= '0;
         chan_pend_q <= 1'b0;
         tx_q        <= 1'b0;
         tx_data_q   <= '0;
      end else begin
         evt_v_q   <= 1'b1;
         evt_a_q   <= '0;
         tx_q      <= c_data;
         tx_data_q <= link.cmd_arg[rmcs_pkg::DATA_W-1:0];
         chan_pend_q <= linked;
         if (!started_q)
            evt_v_q <= cnt_q == 32'd2;
         if (!started_q)
            evt_c_q <= rmcs_pkg::RMCS_EVT_READY;
         else if (bad)
            evt_c_q <= rmcs_pkg::RMCS_EVT_ERROR;
         else if (ok && !c_cfg)
            evt_c_q <= rmcs_pkg::RMCS_EVT_DONE;
         else if (cnt_done)
            evt_c_q <= rmcs_pkg::RMCS_EVT_DONE;
         else if (linked)
            evt_c_q <= rmcs_pkg::RMCS_EVT_LINK_UP;
         else if (chan_pend_q) begin
            evt_c_q <= rmcs_pkg::RMCS_EVT_CHANNEL;
            evt_a_q <= 8'h01;
         end else if (adv_to)
            evt_c_q <= rmcs_pkg::RMCS_EVT_ADV_TO;
         else if (lost)
            evt_c_q <= rmcs_pkg::RMCS_EVT_LINK_DN;
         else if (rx_s2_q && mode_q == rmcs_pkg::RMCS_M_CONN) begin
            evt_c_q <= rmcs_pkg::RMCS_EVT_DATA_RX;
            evt_a_q <= rxd_s2_q;
         end else begin
            evt_v_q <= 1'b0;
            evt_c_q <= rmcs_pkg::RMCS_EVT_NONE;
         end
      end
   end

   logic [rmcs_pkg::UUID_W-1:0] uuid_q_d, uuid_q;
   rmcs_base_store u_bases (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .wr_en    (c_base),
      .wr_idx   (link.cmd_idx),
      .wr_base  (link.cmd_arg),
      .rd_idx   (link.cmd_idx),
      .rd_short (link.cmd_arg[rmcs_pkg::SHORT_W-1:0]),
      .rd_uuid  (uuid_q_d)
   );
   always_ff @(posedge clk) begin
      if (sys_rst)
         uuid_q <= '0;
      else
         uuid_q <= uuid_q_d;
   end

   assign link.evt_valid = evt_v_q;
   assign link.evt_code  = evt_c_q;
   assign link.evt_arg   = evt_a_q;
   assign radio_tx       = tx_q;
   assign radio_tx_data  = tx_data_q;
   assign mode           = mode_q;
   assign adv_kind       = adv_q;
   assign cfg_locked     = lock_q;
   assign bonded         = bond_q;
   assign uuid_out       = uuid_q;
endmodule : rmcs_device
`default_nettype wire

// ===== verification/rmcs_link_asserts.sv
// Assertions on the command and event link between the two ends
`timescale 1ns/1ps
`default_nettype none
module rmcs_link_asserts (
   input wire logic                        clk,
   input wire logic                        sys_rst,
   input wire logic                        cmd_valid,
   input wire rmcs_pkg::rmcs_cmd_t         cmd_code,
   input wire logic                        evt_valid,
   input wire rmcs_pkg::rmcs_evt_t         evt_code,
   input wire logic [rmcs_pkg::DATA_W-1:0] evt_arg
);
   logic rdy_q;
   logic pend_q;
   logic open_q;
   wire logic ans = evt_valid && (evt_code == rmcs_pkg::RMCS_EVT_DONE
                    || evt_code == rmcs_pkg::RMCS_EVT_ERROR);
   wire logic rdy = evt_valid && evt_code == rmcs_pkg::RMCS_EVT_READY;
   // A refused stored write answers with an error at once, which is legal
   wire logic done_ev = evt_valid && evt_code == rmcs_pkg::RMCS_EVT_DONE;
   wire logic chan = evt_valid && evt_code == rmcs_pkg::RMCS_EVT_CHANNEL
                     && evt_arg != 8'h00;
   wire logic slow = cmd_code == rmcs_pkg::RMCS_CMD_CFG_VOL
                     || cmd_code == rmcs_pkg::RMCS_CMD_CFG_NVM;
   // Pending clears only on an answer, so a stray event cannot free it
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdy_q  <= 1'b0;
         pend_q <= 1'b0;
         open_q <= 1'b0;
      end else begin
         rdy_q  <= rdy_q | rdy;
         pend_q <= cmd_valid | (pend_q & ~ans);
         open_q <= open_q | chan;
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   sequence s_link;
      evt_valid && evt_code == rmcs_pkg::RMCS_EVT_LINK_UP;
   endsequence
   sequence s_chan;
      chan;
   endsequence
   cmd_after_rdy_a: assert property (cmd_valid |-> rdy_q)
      else $error("command before ready notice");
   data_after_open_a: assert property (
      cmd_valid && cmd_code == rmcs_pkg::RMCS_CMD_DATA |-> open_q)
      else $error("data command before open channel");
   one_pending_a: assert property (cmd_valid |-> !pend_q)
      else $error("second command while one outstanding");
   cmd_pulse_a: assert property (cmd_valid |=> !cmd_valid)
      else $error("command strobe longer than one cycle");
   quick_answer_a: assert property (cmd_valid && !slow |=> ans)
      else $error("no answer in the cycle after command");
   nvm_slow_a: assert property (
      cmd_valid && cmd_code == rmcs_pkg::RMCS_CMD_CFG_NVM |=> (!done_ev) [*8])
      else $error("stored write answered too soon");
   link_then_chan_a: assert property (s_link |=> s_chan)
      else $error("link up not followed by channel notice");
   ready_once_a: assert property (rdy |-> !rdy_q)
      else $error("ready notice repeated");
   ready_soon_a: assert property ($fell(sys_rst) |-> ##[0:8] rdy)
      else $error("no ready notice after reset");
endmodule : rmcs_link_asserts
`default_nettype wire

// ===== verification/testbench.sv
// Testbench joining controller and device ends over the link
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam int VOL = 20;
   localparam int NVM = 60;
   localparam int ADV = 50;
   logic                 clk       = 1'b0;
   logic                 sys_rst   = 1'b1;
   logic                 strap     = 1'b0;
   logic                 p_conn    = 1'b0;
   logic                 p_loss    = 1'b0;
   logic                 p_rx      = 1'b0;
   logic                 req_valid = 1'b0;
   logic [3:0]           req_code  = 4'h0;
   logic [127:0]         req_arg   = '0;
   logic [2:0]           req_idx   = 3'h0;
   logic [7:0]           last_tx   = 8'h00;
   logic                 req_ready, done, timeout, connected;
   logic                 radio_tx, locked, bonded;
   logic [3:0]           done_code;
   logic [7:0]           tx_data;
   logic [127:0]         uuid;
   rmcs_pkg::rmcs_mode_t mode;
   rmcs_pkg::rmcs_adv_t  adv;
   int                   n_errors   = 0;
   int                   num_checks = 0;
   int                   cyc;
   rmcs_if lnk ();
   always #12.5 clk = ~clk;
   always @(posedge clk)
      if (radio_tx === 1'b1) last_tx <= tx_data;
   rmcs_ctrl #(.ANS_CYC(200)) rmcs_ctrl_i (
      .clk(clk), .sys_rst(sys_rst), .link(lnk), .req_valid(req_valid),
      .req_code(req_code), .req_arg(req_arg), .req_idx(req_idx),
      .req_ready(req_ready), .done(done), .done_code(done_code),
      .timeout(timeout), .connected(connected));
   rmcs_device #(.VOL_CYC(VOL), .NVM_CYC(NVM), .ADV_CYC(ADV)) rmcs_device_i (
      .clk(clk), .sys_rst(sys_rst), .link(lnk), .nvm_cfg_present(strap),
      .peer_connect(p_conn), .peer_loss(p_loss), .peer_rx(p_rx),
      .peer_rx_data(8'h5A), .radio_tx(radio_tx), .radio_tx_data(tx_data),
      .mode(mode), .adv_kind(adv), .cfg_locked(locked), .bonded(bonded),
      .uuid_out(uuid));
   rmcs_link_asserts rmcs_link_asserts_i (
      .clk(clk), .sys_rst(sys_rst), .cmd_valid(lnk.cmd_valid),
      .cmd_code(lnk.cmd_code), .evt_valid(lnk.evt_valid),
      .evt_code(lnk.evt_code), .evt_arg(lnk.evt_arg));
   task automatic stop_test;
      if (n_errors == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : stop_test
   task automatic check(string what, logic [127:0] seen, logic [127:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check
   // Bounded waits: a hang counts as a mismatch and ends the run
   task automatic cmd(rmcs_pkg::rmcs_cmd_t c, logic [127:0] a, logic [2:0] i,
                      rmcs_pkg::rmcs_evt_t e);
      int k;
      k = 0;
      do begin
         @(posedge clk);
         k++;
         if (k > 400) check("req_ready", 1'b0, 1'b1);
         if (k > 400) stop_test();
      end while (req_ready !== 1'b1);
      req_valid <= 1'b1;
      req_code  <= c;
      req_arg   <= a;
      req_idx   <= i;
      @(posedge clk);
      req_valid <= 1'b0;
      cyc = 0;
      do begin
         @(posedge clk);
         cyc++;
         if (timeout !== 1'b0) check("timeout", timeout, 1'b0);
         if (cyc > 400) check("done", 1'b0, 1'b1);
         if (cyc > 400) stop_test();
      end while (done !== 1'b1);
      check("done_code", done_code, e);
   endtask : cmd
   task automatic wait_mode(rmcs_pkg::rmcs_mode_t m, int lim);
      int k;
      k = 0;
      while (mode !== m && k < lim) begin
         @(posedge clk);
         k++;
      end
      check("mode", mode, m);
      if (mode !== m) stop_test();
   endtask : wait_mode
   task automatic do_reset(logic s);
      strap   <= s;
      sys_rst <= 1'b1;
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
   endtask : do_reset
   task automatic t_boot;
      do_reset(1'b0);
      cmd(rmcs_pkg::RMCS_CMD_CONNECT, '0, 3'h0,
          rmcs_pkg::RMCS_EVT_ERROR);
      check("mode", mode, rmcs_pkg::RMCS_M_SETUP);
      check("locked", locked, 1'b0);
   endtask : t_boot
   task automatic t_setup;
      logic [127:0] x;
      for (int b = 0; b < 5; b++)
         cmd(rmcs_pkg::RMCS_CMD_BASE, {16{8'(8'h21 + b)}}, 3'(b),
             rmcs_pkg::RMCS_EVT_DONE);
      // Refused command still drives index and short form to the store
      cmd(rmcs_pkg::RMCS_CMD_WAKEUP, 128'h5AC3, 3'h3,
          rmcs_pkg::RMCS_EVT_ERROR);
      x = {16{8'h24}};
      x[111:96] = 16'h5AC3;
      check("uuid", uuid, x);
      cmd(rmcs_pkg::RMCS_CMD_CFG_VOL, '0, 3'h0,
          rmcs_pkg::RMCS_EVT_DONE);
      check("vol_time", cyc >= VOL, 1'b1);
      check("mode", mode, rmcs_pkg::RMCS_M_STANDBY);
   endtask : t_setup
   task automatic t_link;
      cmd(rmcs_pkg::RMCS_CMD_CONNECT, '0, 3'h0,
          rmcs_pkg::RMCS_EVT_DONE);
      check("mode", mode, rmcs_pkg::RMCS_M_ADV);
      check("adv", adv, rmcs_pkg::RMCS_ADV_GENERAL);
      wait_mode(rmcs_pkg::RMCS_M_STANDBY, ADV + 20);
      cmd(rmcs_pkg::RMCS_CMD_BOND, '0, 3'h0,
          rmcs_pkg::RMCS_EVT_DONE);
      check("adv", adv, rmcs_pkg::RMCS_ADV_LIMITED);
      p_conn <= 1'b1;
      wait_mode(rmcs_pkg::RMCS_M_CONN, 10);
      repeat (ADV + 10) @(posedge clk);
      check("mode", mode, rmcs_pkg::RMCS_M_CONN);
      check("connected", connected, 1'b1);
      cmd(rmcs_pkg::RMCS_CMD_SLEEP, '0, 3'h0,
          rmcs_pkg::RMCS_EVT_ERROR);
      cmd(rmcs_pkg::RMCS_CMD_DATA, 128'hC7, 3'h0,
          rmcs_pkg::RMCS_EVT_DONE);
      check("tx_data", last_tx, 8'hC7);
      // Receive level passes two synchroniser stages before the event
      p_rx <= 1'b1;
      repeat (4) @(posedge clk);
      check("rx_code", lnk.evt_code, rmcs_pkg::RMCS_EVT_DATA_RX);
      check("rx_arg", lnk.evt_arg, 8'h5A);
      p_rx <= 1'b0;
      repeat (4) @(posedge clk);
      p_conn <= 1'b0;
      p_loss <= 1'b1;
      wait_mode(rmcs_pkg::RMCS_M_STANDBY, 10);
      p_loss <= 1'b0;
      check("bonded", bonded, 1'b1);
      cmd(rmcs_pkg::RMCS_CMD_CONNECT, '0, 3'h0,
          rmcs_pkg::RMCS_EVT_DONE);
      check("adv", adv, rmcs_pkg::RMCS_ADV_NONDISC);
      wait_mode(rmcs_pkg::RMCS_M_STANDBY, ADV + 20);
   endtask : t_link
   task automatic t_sleep;
      cmd(rmcs_pkg::RMCS_CMD_SLEEP, '0, 3'h0,
          rmcs_pkg::RMCS_EVT_DONE);
      check("mode", mode, rmcs_pkg::RMCS_M_SLEEP);
      cmd(rmcs_pkg::RMCS_CMD_TEST, '0, 3'h0,
          rmcs_pkg::RMCS_EVT_ERROR);
      cmd(rmcs_pkg::RMCS_CMD_WAKEUP, '0, 3'h0,
          rmcs_pkg::RMCS_EVT_DONE);
      check("mode", mode, rmcs_pkg::RMCS_M_STANDBY);
      check("bonded", bonded, 1'b1);
      cmd(rmcs_pkg::RMCS_CMD_TEST, '0, 3'h0,
          rmcs_pkg::RMCS_EVT_DONE);
      check("mode", mode, rmcs_pkg::RMCS_M_TEST);
      check("bonded", bonded, 1'b0);
      cmd(rmcs_pkg::RMCS_CMD_SETUP, '0, 3'h0,
          rmcs_pkg::RMCS_EVT_DONE);
      check("mode", mode, rmcs_pkg::RMCS_M_SETUP);
   endtask : t_sleep
   task automatic t_nvm;
      cmd(rmcs_pkg::RMCS_CMD_CFG_NVM, '0, 3'h0,
          rmcs_pkg::RMCS_EVT_DONE);
      check("nvm_time", cyc >= NVM, 1'b1);
      check("locked", locked, 1'b1);
      cmd(rmcs_pkg::RMCS_CMD_SETUP, '0, 3'h0,
          rmcs_pkg::RMCS_EVT_DONE);
      cmd(rmcs_pkg::RMCS_CMD_CFG_VOL, '0, 3'h0,
          rmcs_pkg::RMCS_EVT_ERROR);
      do_reset(1'b1);
      wait_mode(rmcs_pkg::RMCS_M_STANDBY, 20);
      check("locked", locked, 1'b1);
      do_reset(1'b0);
      cmd(rmcs_pkg::RMCS_CMD_CONNECT, '0, 3'h0,
          rmcs_pkg::RMCS_EVT_ERROR);
      check("mode", mode, rmcs_pkg::RMCS_M_SETUP);
   endtask : t_nvm
   initial begin
      t_boot();
      t_setup();
      t_link();
      t_sleep();
      t_nvm();
      stop_test();
   end
endmodule : testbench
`default_nettype wire
